// >>> src/swm_host_port.sv
// Single-wire bus master: indexed register port, tick divider, link engine.
// What this block does
// - Processor uses only index register EEh and data register EFh.
// - Low three index bits select the internal register; upper bits ignored.
// - All internal registers read/write except the read-only flag register and command bit 3, which reads the line level.
// - Data buffer writes load transmit holding; reads return receive buffer.
// - Index 110/111: reads return 00h, writes change nothing.
// - Device makes every line timing pattern and sequence itself.
// - Bus events set flags; enabled flags raise the interrupt request.
// - All line patterns are timed from a 1 MHz base tick.
// - Prescale codes 00..11 divide the system clock by 1, 3, 5, 7.
// - Divide field further divides by two to the field value.
// - Divisor bit 7 enables tick generation; zero stops it.
// - Modes: direct line control, overdrive timing.
// - Reset command resets line, clears search, self-clears, sets flags.
// - Shifter load clears shifter-empty, sets holding-empty; LSB first.
`timescale 1ns/1ps
module swm_host_port
  import swm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire swm_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic irq
);
  logic [7:0] index_select_r, index_select_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] tx_hold_r, tx_hold_nxt;
  logic [7:0] rx_buf_r, rx_buf_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] enables_r, enables_nxt;
  logic [7:0] divisor_r, divisor_nxt;
  logic [7:0] control_r, control_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [2:0] pre_cnt_r, pre_cnt_nxt;
  logic [6:0] div_cnt_r, div_cnt_nxt;
  logic tick_r, tick_nxt;
  swm_state_t state_r, state_nxt;
  logic [9:0] time_r, time_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic presence_r, presence_nxt;
  logic drive_r, drive_nxt;
  logic line_m_r, line_s_r;
  logic [2:0] pre_top;
  logic [6:0] div_top;
  logic idx_wr, idx_rd, data_wr, data_rd;
  logic [2:0] idx;
  logic od;
  logic [9:0] t_low, t_sample, t_end;

  assign idx = index_select_r[2:0];
  assign idx_wr = sfr_req.wr && (sfr_req.addr == SWM_SFR_INDEX);
  assign idx_rd = sfr_req.rd && (sfr_req.addr == SWM_SFR_INDEX);
  assign data_wr = sfr_req.wr && (sfr_req.addr == SWM_SFR_DATA);
  assign data_rd = sfr_req.rd && (sfr_req.addr == SWM_SFR_DATA);
  assign od = control_r[SWM_CTL_OD];
  assign sfr_rdata = rdata_r;
  assign line_out = 1'b0;
  assign line_oe = drive_r;
  assign irq = irq_r;

  // Prescaler top is 2*code, giving 1, 3, 5 or 7 cycles per step.
  assign pre_top = {divisor_r[1:0], 1'b0};
  assign div_top = 7'((8'h01 << divisor_r[4:2]) - 8'h01);

  // Divider chain makes a one-cycle tick enable, never a derived clock.
  always_comb begin
    pre_cnt_nxt = pre_cnt_r;
    div_cnt_nxt = div_cnt_r;
    tick_nxt = 1'b0;
    if (!divisor_r[SWM_DIV_EN]) begin
      pre_cnt_nxt = '0;
      div_cnt_nxt = '0;
    end else if (pre_cnt_r >= pre_top) begin
      pre_cnt_nxt = '0;
      if (div_cnt_r >= div_top) begin
        div_cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 7'h01;
      end
    end else begin
      pre_cnt_nxt = pre_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_cnt_r <= '0;
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // The line is a pin, so it is synchronised before anything reads it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      line_m_r <= 1'b1;
      line_s_r <= 1'b1;
    end else begin
      line_m_r <= line_in;
      line_s_r <= line_m_r;
    end
  end

  always_comb begin
    t_low = od ? SWM_T_OD_LOW1 : SWM_T_BIT_LOW1;
    t_sample = od ? SWM_T_OD_SAMPLE : SWM_T_BIT_SAMPLE;
    t_end = od ? SWM_T_OD_END : SWM_T_BIT_END;
    if (!shift_r[0]) begin
      t_low = od ? SWM_T_OD_LOW0 : SWM_T_BIT_LOW0;
    end
  end

  // Register port, flags and link engine share one next-state process, since
  // software writes and hardware events hit the same bits in one cycle.
  always_comb begin
    index_select_nxt = index_select_r;
    cmd_nxt = cmd_r;
    tx_hold_nxt = tx_hold_r;
    rx_buf_nxt = rx_buf_r;
    flags_nxt = flags_r;
    enables_nxt = enables_r;
    divisor_nxt = divisor_r;
    control_nxt = control_r;
    rdata_nxt = rdata_r;
    state_nxt = state_r;
    time_nxt = time_r;
    shift_nxt = shift_r;
    rx_shift_nxt = rx_shift_r;
    bit_nxt = bit_r;
    presence_nxt = presence_r;
    drive_nxt = 1'b0;
    if (idx_wr) begin
      index_select_nxt = sfr_req.wdata;
    end
    if (idx_rd) begin
      rdata_nxt = index_select_r;
    end
    if (data_rd) begin
      case (idx)
        SWM_IDX_CMD: rdata_nxt = {cmd_r[7:4], line_s_r, cmd_r[2:0]};
        SWM_IDX_BUF: begin
          rdata_nxt = rx_buf_r;
          flags_nxt[SWM_FL_RBF] = 1'b0;
        end
        SWM_IDX_FLAGS: rdata_nxt = flags_r;
        SWM_IDX_ENABLES: rdata_nxt = enables_r;
        SWM_IDX_DIVISOR: rdata_nxt = divisor_r;
        SWM_IDX_CONTROL: rdata_nxt = control_r;
        default: rdata_nxt = SWM_INVALID_READ;
      endcase
    end
    if (data_wr) begin
      case (idx)
        SWM_IDX_CMD: begin
          cmd_nxt = sfr_req.wdata;
          if (sfr_req.wdata[SWM_CMD_RST]) begin
            cmd_nxt[SWM_CMD_SRA] = 1'b0;
          end
        end
        SWM_IDX_BUF: begin
          tx_hold_nxt = sfr_req.wdata;
          flags_nxt[SWM_FL_TBE] = 1'b0;
        end
        SWM_IDX_FLAGS: flags_nxt = flags_nxt;
        SWM_IDX_ENABLES: enables_nxt = sfr_req.wdata;
        SWM_IDX_DIVISOR: divisor_nxt = sfr_req.wdata;
        SWM_IDX_CONTROL: control_nxt = sfr_req.wdata;
        default: cmd_nxt = cmd_r;
      endcase
    end
    // Forced low only while both the command and its enable are set.
    if (cmd_r[SWM_CMD_FOW] && control_r[SWM_CTL_ENFOW]) begin
      drive_nxt = 1'b1;
    end
    case (state_r)
      SWM_IDLE: begin
        time_nxt = '0;
        // Nothing starts while the tick is stopped, or the line would hang low.
        if (!divisor_r[SWM_DIV_EN]) begin
          state_nxt = SWM_IDLE;
        end else if (cmd_r[SWM_CMD_RST]) begin
          state_nxt = SWM_RESET;
          presence_nxt = 1'b0;
        end else if (!flags_r[SWM_FL_TBE] && flags_r[SWM_FL_TX_SHIFTER_EMPTY] &&
            !(flags_r[SWM_FL_RBF] && flags_r[SWM_FL_RX_SHIFTER_FULL])) begin
          shift_nxt = tx_hold_nxt;
          flags_nxt[SWM_FL_TX_SHIFTER_EMPTY] = 1'b0;
          flags_nxt[SWM_FL_TBE] = 1'b1;
          flags_nxt[SWM_FL_RX_SHIFTER_FULL] = 1'b1;
          bit_nxt = '0;
          state_nxt = SWM_BIT;
        end
      end
      SWM_RESET: begin
        if (time_r < (od ? SWM_T_OD_RST_LOW : SWM_T_RST_LOW)) begin
          drive_nxt = 1'b1;
        end
        if (tick_r) begin
          time_nxt = time_r + 10'd1;
          if (time_r == (od ? SWM_T_OD_RST_SAMPLE : SWM_T_RST_SAMPLE) &&
              !line_s_r) begin
            presence_nxt = 1'b1;
          end
          if (time_r >= (od ? SWM_T_OD_RST_END : SWM_T_RST_END)) begin
            state_nxt = SWM_IDLE;
            cmd_nxt[SWM_CMD_RST] = 1'b0;
            flags_nxt[SWM_FL_PD] = 1'b1;
            flags_nxt[SWM_FL_PDR] = control_r[SWM_CTL_PPM] ? 1'b0 :
                !presence_r;
            // A finished line reset readies both transmit stages. A byte
            // written before it completes is dropped, since data may only
            // follow a reset.
            flags_nxt[SWM_FL_TX_SHIFTER_EMPTY] = 1'b1;
            flags_nxt[SWM_FL_TBE] = 1'b1;
          end
        end
      end
      SWM_BIT: begin
        if (time_r < t_low) begin
          drive_nxt = 1'b1;
        end
        if (tick_r) begin
          time_nxt = time_r + 10'd1;
          if (time_r == t_sample) begin
            rx_shift_nxt = {line_s_r, rx_shift_r[7:1]};
          end
          if (time_r >= t_end) begin
            time_nxt = '0;
            shift_nxt = {1'b1, shift_r[7:1]};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == SWM_BIT_LAST) begin
              state_nxt = SWM_IDLE;
              flags_nxt[SWM_FL_TX_SHIFTER_EMPTY] = 1'b1;
              if (!flags_nxt[SWM_FL_RBF]) begin
                rx_buf_nxt = rx_shift_r;
                flags_nxt[SWM_FL_RBF] = 1'b1;
                flags_nxt[SWM_FL_RX_SHIFTER_FULL] = 1'b0;
              end
            end
          end
        end
      end
      default: state_nxt = SWM_IDLE;
    endcase
    // A held receive byte moves over once software empties the buffer.
    if (state_r == SWM_IDLE && flags_r[SWM_FL_RX_SHIFTER_FULL] &&
        !flags_nxt[SWM_FL_RBF] && state_nxt == SWM_IDLE) begin
      rx_buf_nxt = rx_shift_r;
      flags_nxt[SWM_FL_RBF] = 1'b1;
      flags_nxt[SWM_FL_RX_SHIFTER_FULL] = 1'b0;
    end
    flags_nxt[SWM_FL_LOW] = !line_s_r;
    flags_nxt[SWM_FL_SHORT] = state_r != SWM_IDLE && !drive_r &&
        !line_s_r && time_r < t_low;
  end

  assign irq_nxt = |(flags_r & enables_r);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      index_select_r <= SWM_RESET_VAL;
      cmd_r <= SWM_RESET_VAL;
      tx_hold_r <= SWM_RESET_VAL;
      rx_buf_r <= SWM_RESET_VAL;
      flags_r <= SWM_RESET_VAL;
      enables_r <= SWM_RESET_VAL;
      divisor_r <= SWM_RESET_VAL;
      control_r <= SWM_RESET_VAL;
      rdata_r <= SWM_RESET_VAL;
      irq_r <= 1'b0;
      state_r <= SWM_IDLE;
      time_r <= '0;
      shift_r <= SWM_RESET_VAL;
      rx_shift_r <= SWM_RESET_VAL;
      bit_r <= '0;
      presence_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      index_select_r <= index_select_nxt;
      cmd_r <= cmd_nxt;
      tx_hold_r <= tx_hold_nxt;
      rx_buf_r <= rx_buf_nxt;
      flags_r <= flags_nxt;
      enables_r <= enables_nxt;
      divisor_r <= divisor_nxt;
      control_r <= control_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      state_r <= state_nxt;
      time_r <= time_nxt;
      shift_r <= shift_nxt;
      rx_shift_r <= rx_shift_nxt;
      bit_r <= bit_nxt;
      presence_r <= presence_nxt;
      drive_r <= drive_nxt;
    end
  end
endmodule // swm_host_port

// >>> src/swm_pkg.sv
// Package for the single-wire bus master host port: map, fields, timing.
package swm_pkg;
  localparam logic [7:0] SWM_SFR_INDEX = 8'hEE;
  localparam logic [7:0] SWM_SFR_DATA = 8'hEF;
  localparam logic [2:0] SWM_IDX_CMD = 3'h0;
  localparam logic [2:0] SWM_IDX_BUF = 3'h1;
  localparam logic [2:0] SWM_IDX_FLAGS = 3'h2;
  localparam logic [2:0] SWM_IDX_ENABLES = 3'h3;
  localparam logic [2:0] SWM_IDX_DIVISOR = 3'h4;
  localparam logic [2:0] SWM_IDX_CONTROL = 3'h5;
  localparam logic [7:0] SWM_RESET_VAL = 8'h00;
  localparam logic [7:0] SWM_INVALID_READ = 8'h00;
  // Command bits.
  localparam int SWM_CMD_RST = 0;
  localparam int SWM_CMD_SRA = 1;
  localparam int SWM_CMD_FOW = 2;
  localparam int SWM_CMD_IN = 3;
  // Flag bits.
  localparam int SWM_FL_PD = 0;
  localparam int SWM_FL_PDR = 1;
  localparam int SWM_FL_TBE = 2;
  localparam int SWM_FL_TX_SHIFTER_EMPTY = 3;
  localparam int SWM_FL_RBF = 4;
  localparam int SWM_FL_RX_SHIFTER_FULL = 5;
  localparam int SWM_FL_SHORT = 6;
  localparam int SWM_FL_LOW = 7;
  // Divisor and control bits.
  localparam int SWM_DIV_EN = 7;
  localparam int SWM_CTL_ENFOW = 2;
  localparam int SWM_CTL_PPM = 1;
  localparam int SWM_CTL_OD = 6;
  // Timing in base ticks of 1 us (standard mode, overdrive is shorter).
  localparam logic [9:0] SWM_T_RST_LOW = 10'd480;
  localparam logic [9:0] SWM_T_RST_SAMPLE = 10'd550;
  localparam logic [9:0] SWM_T_RST_END = 10'd960;
  localparam logic [9:0] SWM_T_OD_RST_LOW = 10'd56;
  localparam logic [9:0] SWM_T_OD_RST_SAMPLE = 10'd64;
  localparam logic [9:0] SWM_T_OD_RST_END = 10'd112;
  localparam logic [9:0] SWM_T_BIT_LOW1 = 10'd5;
  localparam logic [9:0] SWM_T_BIT_SAMPLE = 10'd15;
  localparam logic [9:0] SWM_T_BIT_LOW0 = 10'd60;
  localparam logic [9:0] SWM_T_BIT_END = 10'd70;
  localparam logic [9:0] SWM_T_OD_LOW1 = 10'd1;
  localparam logic [9:0] SWM_T_OD_SAMPLE = 10'd2;
  localparam logic [9:0] SWM_T_OD_LOW0 = 10'd8;
  localparam logic [9:0] SWM_T_OD_END = 10'd10;
  localparam logic [2:0] SWM_BIT_LAST = 3'h7;
  localparam logic [1:0] SWM_PRE_ONE = 2'h0;

  typedef enum logic [1:0] {
    SWM_IDLE = 2'b00,
    SWM_RESET = 2'b01,
    SWM_BIT = 2'b10
  } swm_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swm_sfr_req_t;
endpackage

// >>> verif/swm_host_port_asserts.sv
// Checker for the single-wire master host port.
`timescale 1ns/1ps
module swm_host_port_chk
  import swm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire swm_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic irq
);
  logic [7:0] idx_r, dv_r, ctl_r, en_r;
  logic [11:0] low_r;
  logic wd, rdd;
  assign wd = sfr_req.wr && sfr_req.addr == SWM_SFR_DATA;
  assign rdd = sfr_req.rd && sfr_req.addr == SWM_SFR_DATA;
  // Shadow copies let the checker know the mode without seeing inside.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idx_r <= 8'h00;
      dv_r <= 8'h00;
      ctl_r <= 8'h00;
      en_r <= 8'h00;
    end else begin
      if (sfr_req.wr && sfr_req.addr == SWM_SFR_INDEX) idx_r <= sfr_req.wdata;
      if (wd && idx_r[2:0] == SWM_IDX_DIVISOR) dv_r <= sfr_req.wdata;
      if (wd && idx_r[2:0] == SWM_IDX_CONTROL) ctl_r <= sfr_req.wdata;
      if (wd && idx_r[2:0] == SWM_IDX_ENABLES) en_r <= sfr_req.wdata;
    end
    low_r <= line_oe ? low_r + 12'h001 : 12'h000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  line_idle_a: assert property (line_out == 1'b0)
    else $error("line data output not held low");
  reset_out_a: assert property ($fell(srst) |-> sfr_rdata == 8'h00
    && !line_oe && !irq) else $error("outputs not cleared by reset");
  rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  index_read_a: assert property (sfr_req.rd && !sfr_req.wr
    && sfr_req.addr == SWM_SFR_INDEX |=> sfr_rdata == $past(idx_r))
    else $error("index read back wrong");
  bad_index_a: assert property (rdd && idx_r[2:1] == 2'b11
    |=> sfr_rdata == SWM_INVALID_READ) else $error("bad index read data");
  div_read_a: assert property (rdd && idx_r[2:0] == SWM_IDX_DIVISOR
    |=> (sfr_rdata & 8'h9F) == ($past(dv_r) & 8'h9F))
    else $error("divisor read back wrong");
  tick_off_a: assert property (!dv_r[SWM_DIV_EN]
    && !ctl_r[SWM_CTL_ENFOW] && !line_oe |=> !line_oe)
    else $error("line driven with tick stopped");
  low_len_a: assert property ($fell(line_oe) && dv_r == 8'h80
    && !ctl_r[SWM_CTL_ENFOW] && low_r > 12'd100
    |-> low_r inside {[12'd479:12'd481]}) else $error("reset low width");
  irq_off_a: assert property (en_r == 8'h00 |=> !irq)
    else $error("request raised with all sources masked");
  cover property ($fell(line_oe) && low_r > 12'd400);
  cover property ($rose(irq));
  cover property (rdd && idx_r[2:1] == 2'b11);
endmodule // swm_host_port_chk

// >>> verif/swm_slave_model.sv
// Behavioural single-wire slave that answers a line reset with presence.
`timescale 1ns/1ps
module swm_slave_model #(
  parameter int RST_MIN = 400,
  parameter int DLY = 30,
  parameter int LEN = 150
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic line_oe,
  input wire logic present,
  output logic line_lvl
);
  logic [12:0] low_c;
  logic [12:0] wait_c;
  // The line has a pull-up, so a released line reads high.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_c <= 13'h0000;
      wait_c <= 13'h0000;
    end else begin
      low_c <= line_oe ? low_c + 13'h0001 : 13'h0000;
      if (present && !line_oe && low_c >= RST_MIN) begin
        wait_c <= 13'h0001;
      end else if (wait_c != 13'h0000) begin
        wait_c <= (wait_c == DLY + LEN) ? 13'h0000 : wait_c + 13'h0001;
      end
    end
  end
  assign line_lvl = !(line_oe || wait_c > DLY);
endmodule // swm_slave_model

// >>> verif/testbench.sv
// Self-checking bench for the single-wire master host port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end \
end
module testbench;
  import swm_pkg::*;
  logic clk_sys, srst, line_in, line_out, line_oe, irq, present;
  logic [7:0] sfr_rdata, v;
  swm_sfr_req_t sfr_req;
  int bad_count, tests_run, n;
  swm_host_port dut (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .irq(irq));
  swm_slave_model slave (.clk_sys(clk_sys), .srst(srst), .line_oe(line_oe),
    .present(present), .line_lvl(line_in));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, d, input logic r);
    @(negedge clk_sys);
    sfr_req = '{a, d, !r, r};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
    v = sfr_rdata;
  endtask
  task automatic rg(input logic [7:0] i, d, input logic r);
    acc(SWM_SFR_INDEX, i, 1'b0);
    acc(SWM_SFR_DATA, d, r);
  endtask
  task automatic wait_done();
    for (n = 0; n < 4000; n++) begin
      rg(8'h00, 8'h00, 1'b1);
      if (v[SWM_CMD_RST] === 1'b0) return;
    end
    bad_count++;
    print_verdict();
  endtask
  // Counts falling edges until line_oe shows lvl; a hang ends the run.
  task automatic wait_oe(input logic lvl, input int lim);
    for (n = 0; n < lim && line_oe !== lvl; n++) @(negedge clk_sys);
    if (n == lim) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rg(8'(i), 8'h00, 1'b1);
      // The idle line reads high in the level bit of the command register.
      `CHK("reset value", (i == 0) ? (8'h01 << SWM_CMD_IN) : SWM_RESET_VAL, v)
    end
    `CHK("line drive", 1'b0, line_oe)
  endtask
  task automatic t_regs();
    rg(8'hFB, 8'h55, 1'b0);
    rg(8'h03, 8'h00, 1'b1);
    `CHK("enables", 8'h55, v)
    rg(8'h02, 8'hFF, 1'b0);
    rg(8'h02, 8'h00, 1'b1);
    `CHK("flags", 8'h00, v)
    rg(8'h06, 8'hAA, 1'b0);
    rg(8'h03, 8'h00, 1'b1);
    `CHK("enables kept", 8'h55, v)
    rg(8'h07, 8'h00, 1'b1);
    `CHK("bad index", SWM_INVALID_READ, v)
    rg(8'h01, 8'hC3, 1'b0);
    rg(8'h01, 8'h00, 1'b1);
    `CHK("rx buffer", 8'h00, v)
    rg(8'h05, 8'h08, 1'b0);
    rg(8'h05, 8'h00, 1'b1);
    `CHK("control", 8'h08, v)
    acc(SWM_SFR_INDEX, 8'h00, 1'b1);
    `CHK("index", 8'h05, v)
    rg(8'h04, 8'h1F, 1'b0);
    rg(8'h04, 8'h00, 1'b1);
    `CHK("divisor", 8'h1F, v)
  endtask
  // The low phase of a line reset is 480 ticks, so its width shows the ratio.
  task automatic t_pulse(input logic [7:0] dv, input logic pres, input int m);
    present = pres;
    rg(8'h04, dv, 1'b0);
    rg(8'h00, 8'h03, 1'b0);
    wait_oe(1'b1, 200);
    wait_oe(1'b0, 12000);
    `CHK("low width", 1'b1, (n - 480 * m) inside {[-2*m:2*m]})
    wait_done();
    `CHK("search bit", 1'b0, v[SWM_CMD_SRA])
    rg(8'h02, 8'h00, 1'b1);
    `CHK("presence flags", {!pres, 1'b1}, v[1:0])
    `CHK("irq", 1'b1, irq)
  endtask
  // Each slot's low pulse gives the bit: short for one, long for zero.
  task automatic t_byte(input logic [7:0] b);
    rg(8'h04, 8'h80, 1'b0);
    rg(8'h01, b, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wait_oe(1'b1, 200);
      wait_oe(1'b0, 200);
      `CHK("slot low", 1'b1, (n - (b[i] ? 5 : 60)) inside {[-1:1]})
    end
    repeat (80) @(negedge clk_sys);
    rg(8'h02, 8'h00, 1'b1);
    `CHK("tx empty", 2'b11, v[SWM_FL_TX_SHIFTER_EMPTY -: 2])
    `CHK("rx full", 1'b1, v[SWM_FL_RBF])
    rg(8'h01, 8'h00, 1'b1);
    `CHK("rx byte", b, v)
  endtask
  task automatic t_od();
    rg(8'h05, 8'h48, 1'b0);
    rg(8'h00, 8'h01, 1'b0);
    wait_oe(1'b1, 200);
    wait_oe(1'b0, 200);
    `CHK("overdrive low", 1'b1, (n - 56) inside {[-1:1]})
    wait_done();
    rg(8'h05, 8'h08, 1'b0);
  endtask
  task automatic t_fow();
    rg(8'h03, 8'h00, 1'b0);
    @(negedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    rg(8'h00, 8'h04, 1'b0);
    repeat (2) @(negedge clk_sys);
    `CHK("force gated", 1'b0, line_oe)
    rg(8'h05, 8'h0C, 1'b0);
    repeat (4) @(negedge clk_sys);
    rg(8'h00, 8'h00, 1'b1);
    `CHK("forced low", 1'b1, line_oe)
    `CHK("level low", 1'b0, v[SWM_CMD_IN])
    rg(8'h00, 8'h00, 1'b0);
    rg(8'h05, 8'h08, 1'b0);
    repeat (4) @(negedge clk_sys);
    rg(8'h00, 8'h00, 1'b1);
    `CHK("level high", 1'b1, v[SWM_CMD_IN])
  endtask
  task automatic t_tick_off();
    rg(8'h04, 8'h00, 1'b0);
    rg(8'h00, 8'h01, 1'b0);
    n = 0;
    repeat (1000) begin
      @(negedge clk_sys);
      if (line_oe !== 1'b0) n++;
    end
    `CHK("stopped drive", 0, n)
    rg(8'h00, 8'h00, 1'b1);
    `CHK("reset pending", 1'b1, v[SWM_CMD_RST])
    rg(8'h04, 8'h80, 1'b0);
    wait_done();
  endtask
  initial begin
    srst = 1'b1;
    sfr_req = '0;
    present = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    t_reset();
    t_regs();
    t_pulse(8'h80, 1'b1, 1);
    t_pulse(8'h81, 1'b0, 3);
    t_pulse(8'h84, 1'b0, 2);
    t_pulse(8'h8A, 1'b0, 20);
    t_pulse(8'h83, 1'b0, 7);
    t_pulse(8'h86, 1'b0, 10);
    t_byte(8'h35);
    t_byte(8'hFF);
    t_od();
    t_fow();
    t_tick_off();
    print_verdict();
  end
endmodule // testbench
bind swm_host_port swm_host_port_chk u_chk (.clk_sys(clk_sys), .srst(srst),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .irq(irq));
